// [verilog/link_rx.sv]
// link_rx: four-bit ddr link port receiver with apb register access
// assumes link pins are asynchronous; link clock far slower than pclk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - link data sampled at link clock edges into rise and fall shift registers
// - each assembled 32-bit word goes into the receive fifo unless the fifo is full
// - with checking on, byte sum of the quad word is compared with checksum
// - bit 32 of fifo word shows block done seen so far in that quad word
// - checksum mismatch raises the checksum error flag
// - with checking off no checksum byte is expected or checked
// - hold-off asserted when the fifo is at least half full
// - local side pops 33-bit words and sees an empty status
// - checksum beat is two nibbles, then one dummy zero beat
// - transfers come in 128-bit quad words, four lines double rate
module link_rx
	import link_rx_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link port
	input wire logic link_clk,
	input wire logic [3:0] link_data,
	input wire logic block_done_n,
	output logic hold_off,
	// local status
	output logic csum_err,
	output logic irq
);
	link_pins_t pins_meta, pins_sync;
	logic clk_prev;
	logic rise_edge, fall_edge;
	logic [15:0] rise_sr, fall_sr, next_fall;
	phase_t phase;
	logic [3:0] beat;
	logic [7:0] csum, beat_byte;
	logic block_seen;
	logic check_en;
	logic [2:0] status, mask, st_set, st_clr;
	logic [FIFO_AW:0] wr_ptr, rd_ptr;
	logic [FIFO_AW:0] count;
	logic fifo_full, fifo_empty;
	logic wr_en, rd_en, csum_bad;
	rx_word_t wr_word, rd_word;
	logic eob_last;
	logic apb_setup, apb_access, apb_done;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser, two stages before any logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_meta <= '0;
			pins_sync <= '0;
			clk_prev <= 1'b0;
		end else begin
			pins_meta <= {link_clk, block_done_n, link_data};
			pins_sync <= pins_meta;
			clk_prev <= pins_sync.clk;
		end
	end

	// link clock edge detection on synchronised copy
	assign rise_edge = pins_sync.clk & ~clk_prev;
	assign fall_edge = ~pins_sync.clk & clk_prev;
	assign next_fall = {pins_sync.data, fall_sr[15:4]};
	assign beat_byte = {pins_sync.data, rise_sr[15:12]};

	////////////////////////////////////////////////////////////////////////
	// rise and fall shift registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_sr <= '0;
			fall_sr <= '0;
		end else begin
			if (rise_edge) begin
				rise_sr <= {pins_sync.data, rise_sr[15:4]};
			end
			if (fall_edge) begin
				fall_sr <= next_fall;
			end
		end
	end

	// beat and phase sequencing, one byte per link period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PH_DATA;
			beat <= '0;
		end else if (fall_edge) begin
			case (phase)
				PH_DATA: begin
					beat <= beat + 4'h1;
					if (beat == LAST_BEAT && check_en) begin
						phase <= PH_CSUM;
					end
				end
				PH_CSUM: begin
					phase <= PH_DUMMY;
				end
				PH_DUMMY: begin
					phase <= PH_DATA;
				end
				default: begin
					phase <= PH_DATA;
				end
			endcase
		end
	end

	// checksum accumulator over data bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csum <= '0;
		end else if (fall_edge && phase == PH_DATA) begin
			csum <= (beat == 4'h0) ? beat_byte : csum + beat_byte;
		end
	end

	// checksum compare at the checksum beat, only when enabled
	assign csum_bad = fall_edge && phase == PH_CSUM && check_en && beat_byte != csum;

	// block done tracking within the current quad word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_seen <= 1'b0;
		end else if (rise_edge && phase == PH_DATA) begin
			block_seen <= (beat == 4'h0) ? ~pins_sync.done_n : block_seen | ~pins_sync.done_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fifo write of each completed word while the fifo is not full
	assign wr_en = fall_edge && phase == PH_DATA && beat[1:0] == WORD_BEAT && !fifo_full;
	always_comb begin
		wr_word.eob = block_seen | ~pins_sync.done_n;
		for (int i = 0; i < 4; i++) begin
			wr_word.data[8*i +: 8] = {next_fall[4*i +: 4], rise_sr[4*i +: 4]};
		end
	end

	// fifo pointers, read pops on a data register setup
	assign count = wr_ptr - rd_ptr;
	assign fifo_full = count == (FIFO_AW+1)'(FIFO_DEPTH);
	assign fifo_empty = count == '0;
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && !pready;
	assign apb_done = psel && penable && pready;
	assign rd_en = apb_setup && !pwrite && paddr == DATA_OFS && !fifo_empty;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (wr_en) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (rd_en) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	rx_mem u_mem (
		.pclk(pclk),
		.wr_en(wr_en),
		.wr_addr(wr_ptr[FIFO_AW-1:0]),
		.wr_word(wr_word),
		.rd_en(rd_en),
		.rd_addr(rd_ptr[FIFO_AW-1:0]),
		.rd_word(rd_word)
	);

	// hold-off toward the sender
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_off <= 1'b0;
		end else begin
			hold_off <= count >= HOLD_LEVEL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky event status, write one to clear, set wins
	assign st_set = {wr_en & wr_word.eob, fall_edge & phase == PH_DATA
		& beat[1:0] == WORD_BEAT & fifo_full, csum_bad};
	assign st_clr = (apb_done && pwrite && paddr == STATUS_OFS) ? pwdata[2:0] : 3'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= STATUS_RST;
		end else begin
			status <= (status & ~st_clr) | st_set;
		end
	end

	// error pin and interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csum_err <= 1'b0;
			irq <= 1'b0;
		end else begin
			csum_err <= status[ST_CSUM_BIT];
			irq <= |(status & mask);
		end
	end

	// control and mask writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			check_en <= CTRL_RST[CTRL_CHECK_BIT];
			mask <= MASK_RST;
		end else if (apb_done && pwrite) begin
			if (paddr == CTRL_OFS) begin
				check_en <= pwdata[CTRL_CHECK_BIT];
			end
			if (paddr == MASK_OFS) begin
				mask <= pwdata[2:0];
			end
		end
	end

	// bit 32 of the last popped word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eob_last <= 1'b0;
		end else if (apb_access && paddr == DATA_OFS && !pwrite) begin
			eob_last <= rd_word.eob;
		end
	end

	// apb answer, ready one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= apb_access;
			pslverr <= apb_access && paddr > FLAG_OFS;
			prdata <= '0;
			if (apb_access && !pwrite) begin
				case (paddr)
					CTRL_OFS: prdata <= 32'(check_en);
					STATUS_OFS: prdata <= 32'(status);
					MASK_OFS: prdata <= 32'(mask);
					DATA_OFS: prdata <= rd_word.data;
					FLAG_OFS: prdata <= {19'h0_0000, count, 5'h00, hold_off,
						fifo_empty, eob_last};
					default: prdata <= '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_word_written: assert property (fall_edge && phase == PH_DATA
		&& beat[1:0] == WORD_BEAT && !fifo_full |-> wr_en ##1 count != '0)
		else $error("completed word not written");
	a_sum_compared: assert property (fall_edge && phase == PH_CSUM && check_en
		&& beat_byte != csum |=> status[ST_CSUM_BIT] ##1 csum_err)
		else $error("bad checksum not flagged");
	a_eob_marked: assert property (wr_en && block_seen |-> wr_word.eob)
		else $error("block done lost");
	a_error_sticky: assert property (status[ST_CSUM_BIT] && !st_clr[ST_CSUM_BIT]
		|=> status[ST_CSUM_BIT])
		else $error("checksum error not sticky");
	a_no_check: assert property (!check_en && phase == PH_DATA |=> phase == PH_DATA)
		else $error("checksum beat without enable");
	a_hold_level: assert property (count >= HOLD_LEVEL |=> hold_off)
		else $error("hold-off missing");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	a_csum_phase: assert property (fall_edge && phase == PH_DATA && beat == LAST_BEAT
		&& check_en |=> phase == PH_CSUM)
		else $error("checksum beat skipped");
	a_dummy_phase: assert property (fall_edge && phase == PH_CSUM
		|=> phase == PH_DUMMY)
		else $error("dummy beat skipped");
	a_quad_wrap: assert property (fall_edge && phase == PH_DATA && beat == LAST_BEAT
		&& !check_en |=> beat == 4'h0 && phase == PH_DATA)
		else $error("quad word length wrong");
endmodule // link_rx

// [verilog/link_rx_pkg.sv]
// link receiver package: register map, fifo geometry, phase codes, carriers
// assumes a 32-bit apb slave on a 100 MHz pclk
package link_rx_pkg;
	// register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h0000;
	localparam logic [11:0] STATUS_OFS = 12'h0004;
	localparam logic [11:0] MASK_OFS = 12'h0008;
	localparam logic [11:0] DATA_OFS = 12'h000C;
	localparam logic [11:0] FLAG_OFS = 12'h0010;
	// field positions
	localparam int CTRL_CHECK_BIT = 0;
	localparam int ST_CSUM_BIT = 0;
	localparam int ST_OVFL_BIT = 1;
	localparam int ST_EOB_BIT = 2;
	localparam int FLAG_EOB_BIT = 0;
	localparam int FLAG_EMPTY_BIT = 1;
	localparam int FLAG_HOLD_BIT = 2;
	localparam int FLAG_COUNT_POS = 8;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	// receive fifo geometry
	localparam int FIFO_WIDTH = 33;
	localparam int FIFO_AW = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] HOLD_LEVEL = 5'h08;
	// beats per quad word (one byte per link clock period)
	localparam logic [3:0] LAST_BEAT = 4'hF;
	localparam logic [1:0] WORD_BEAT = 2'h3;

	// link phase, gray along data -> checksum -> dummy
	typedef enum logic [1:0] {
		PH_DATA = 2'b00,
		PH_CSUM = 2'b01,
		PH_DUMMY = 2'b11
	} phase_t;

	// synchronised link pins
	typedef struct packed {
		logic clk;
		logic done_n;
		logic [3:0] data;
	} link_pins_t;

	// one receive fifo word
	typedef struct packed {
		logic eob;
		logic [31:0] data;
	} rx_word_t;
endpackage

// [verilog/rx_mem.sv]
// rx_mem: receive fifo storage, one write and one registered read port
// assumes pointers and full/empty are kept by the caller
`timescale 1ns/1ps
module rx_mem
	import link_rx_pkg::*;
(
	// clock
	input wire logic pclk,
	// write port
	input wire logic wr_en,
	input wire logic [FIFO_AW-1:0] wr_addr,
	input wire rx_word_t wr_word,
	// read port
	input wire logic rd_en,
	input wire logic [FIFO_AW-1:0] rd_addr,
	output rx_word_t rd_word
);
	rx_word_t mem [FIFO_DEPTH];

	// storage write
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_word;
		end
	end

	// registered read data
	always_ff @(posedge pclk) begin
		if (rd_en) begin
			rd_word <= mem[rd_addr];
		end
	end
endmodule // rx_mem

// [bench/link_tx_model.sv]
// link_tx_model: behavioural four-bit ddr link sender, 160 ns link period
// assumes the receiver samples both link clock edges; clock idles low
`timescale 1ns/1ps
module link_tx_model (
	// link pins
	output logic link_clk,
	output logic [3:0] link_data,
	output logic block_done_n,
	input wire logic hold_off
);
	// cleared by the bench to ignore hold-off and force an overflow
	logic heed_hold = 1'b1;

	// idle levels, data arbitrary while idle
	initial begin
		link_clk = 1'b0;
		link_data = 4'h5;
		block_done_n = 1'b1;
	end

	// one byte: low nibble on rise, high nibble on fall
	task automatic beat(input logic [7:0] b, input logic dn);
		link_data = b[3:0];
		block_done_n = dn;
		#40 link_clk = 1'b1;
		#40 link_data = b[7:4];
		#40 link_clk = 1'b0;
		#40;
	endtask

	// one quad word, low byte first, optional checksum and dummy
	task automatic send_quad(input logic [127:0] qw, input logic done, input logic chk,
		input logic bad);
		logic [7:0] sum;
		int w;
		sum = 8'h00;
		w = 0;
		#3; // link edges land off the pclk edges
		while (heed_hold && hold_off === 1'b1 && w < 1000) begin
			#160;
			w++;
		end
		for (int i = 0; i < 16; i++) begin
			beat(qw[8*i+:8], ~done);
			sum += qw[8*i+:8];
		end
		if (chk) begin
			beat(sum ^ {7'h00, bad}, ~done);
			beat(8'h00, ~done);
		end
		link_data = ~link_data; // released lines show no stale value
		block_done_n = 1'b1;
	endtask
endmodule // link_tx_model

// [bench/tb_link_rx.sv]
// tb_link_rx: apb-driven tests of the link receiver with a link sender model
// assumes 100 MHz pclk and three apb edges per access
`timescale 1ns/1ps
module tb_link_rx
	import link_rx_pkg::*;
;
	localparam logic [127:0] Q0 = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
	localparam logic [127:0] Q1 = 128'hFFFF_0000_A5A5_5A5A_1234_5678_9ABC_DEF0;
	localparam logic [127:0] Q2 = 128'h8000_0001_7FFF_FFFE_0102_0304_FEDC_BA98;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
	logic pready, pslverr, err, link_clk, block_done_n, hold_off, csum_err, irq;
	logic [3:0] link_data;
	int bad_count = 0, checked = 0;

	// 100 MHz clock
	always #5 pclk = ~pclk;

	link_rx u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_clk(link_clk), .link_data(link_data),
		.block_done_n(block_done_n), .hold_off(hold_off), .csum_err(csum_err), .irq(irq));
	link_tx_model u_tx (.link_clk(link_clk), .link_data(link_data),
		.block_done_n(block_done_n), .hold_off(hold_off));

	////////////////////////////////////////////////////////////////////////////////
	// compare and verdict
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		$display("checked %0d, wrong %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// one apb transfer, waits for pready under a bound
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			report_and_stop;
		end else begin
			rv = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// pop one word and its end-of-block bit
	task pop(input logic [31:0] w, input logic e);
		xfer(1'b0, DATA_OFS, 32'h0000_0000);
		chk(rv, w);
		xfer(1'b0, FLAG_OFS, 32'h0000_0000);
		chk({31'h0, rv[FLAG_EOB_BIT]}, {31'h0, e});
	endtask

	// poll fifo count until it reaches c
	task wait_cnt(input logic [4:0] c);
		int n;
		n = 0;
		do begin
			xfer(1'b0, FLAG_OFS, 32'h0000_0000);
			n++;
		end while (rv[12:8] !== c && n < 200);
		chk({27'h0, rv[12:8]}, {27'h0, c});
		if (rv[12:8] !== c) begin
			report_and_stop;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, CTRL_OFS, 32'h0000_0000);
		chk(rv, CTRL_RST);
		xfer(1'b0, STATUS_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
		xfer(1'b0, FLAG_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0002);
		chk({30'h0, hold_off, csum_err}, 32'h0000_0000);
		xfer(1'b0, 12'h014, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rv, 32'h0000_0000);
		$display("test reset values done");
		u_tx.send_quad(Q0, 1'b0, 1'b0, 1'b0);
		u_tx.send_quad(Q1, 1'b0, 1'b0, 1'b0);
		wait_cnt(5'h08);
		chk({31'h0, hold_off}, 32'h0000_0001);
		for (int i = 0; i < 4; i++) pop(Q0[32*i+:32], 1'b0);
		for (int i = 0; i < 4; i++) pop(Q1[32*i+:32], 1'b0);
		xfer(1'b0, FLAG_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0002);
		$display("test unchecked stream done");
		xfer(1'b1, CTRL_OFS, 32'h0000_0001);
		u_tx.send_quad(Q2, 1'b1, 1'b1, 1'b0);
		wait_cnt(5'h04);
		for (int i = 0; i < 4; i++) pop(Q2[32*i+:32], 1'b1);
		xfer(1'b0, STATUS_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0004);
		xfer(1'b1, STATUS_OFS, 32'h0000_0004);
		$display("test block done done");
		u_tx.send_quad(Q1, 1'b0, 1'b1, 1'b1);
		wait_cnt(5'h04);
		xfer(1'b0, STATUS_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0001);
		chk({30'h0, csum_err, irq}, 32'h0000_0002);
		xfer(1'b1, MASK_OFS, 32'h0000_0001);
		xfer(1'b0, MASK_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0001);
		xfer(1'b1, STATUS_OFS, 32'h0000_0001);
		xfer(1'b0, STATUS_OFS, 32'h0000_0000);
		chk({29'h0, rv[0], csum_err, irq}, 32'h0000_0000);
		for (int i = 0; i < 4; i++) pop(Q1[32*i+:32], 1'b0);
		$display("test checksum error done");
		u_tx.heed_hold = 1'b0;
		for (int i = 0; i < 5; i++) u_tx.send_quad(Q0, 1'b0, 1'b1, 1'b0);
		xfer(1'b0, STATUS_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0002);
		xfer(1'b0, FLAG_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_1004);
		chk({31'h0, hold_off}, 32'h0000_0001);
		u_tx.heed_hold = 1'b1;
		$display("test overflow done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, FLAG_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0002);
		xfer(1'b0, STATUS_OFS, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
		xfer(1'b0, CTRL_OFS, 32'h0000_0000);
		chk(rv, CTRL_RST);
		chk({30'h0, hold_off, csum_err}, 32'h0000_0000);
		u_tx.send_quad(Q2, 1'b0, 1'b0, 1'b0);
		wait_cnt(5'h04);
		for (int i = 0; i < 4; i++) pop(Q2[32*i+:32], 1'b0);
		$display("test mid-run reset done");
		report_and_stop;
	end
endmodule // tb_link_rx
